// *** hw/charge_seq_pkg.sv ***
// shared types and constants for the battery charge cycle sequencer
package charge_seq_pkg;

   // clock and timer base
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned TICK_NS       = 1000;
   localparam int unsigned TICK_CYCLES   =
      (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TIMER_W       = 36;

   // bad cell limit: one-half hour, counted in 1 us ticks
   localparam longint unsigned BAD_CELL_MIN   = 30;
   localparam longint unsigned BAD_CELL_TICKS =
      BAD_CELL_MIN * 60 * 1000 * 1000 * 1000 / TICK_NS;
   // safety timer: four hours
   localparam longint unsigned SAFETY_HOURS   = 4;
   localparam longint unsigned SAFETY_TICKS   =
      SAFETY_HOURS * 3600 * 1000 * 1000 * 1000 / TICK_NS;
   // recharge filter: strictly more than 1.3 ms
   localparam longint unsigned RECHARGE_NS    = 1300000;
   localparam longint unsigned RECHARGE_TICKS = RECHARGE_NS / TICK_NS + 1;

   // comparator flags from the analog front end
   typedef struct packed {
      logic bus_above_rise;   // bus input above 3.8 V
      logic bus_above_out;    // bus input 50 mV above system output
      logic bus_below_fall;   // bus input below 3.7 V
      logic bus_below_out;    // bus input 50 mV below system output
      logic below_trickle;    // battery below trickle_threshold
      logic cv_mode;          // charger loop in constant voltage
      logic below_c10;        // charge current below one tenth
      logic below_recharge;   // battery below recharge_threshold
      logic current_limit;    // input current limit active
      logic temp_fault;       // thermistor out of range
      logic over_budget;      // load uses all of the input budget
   } comparator_flags_t;

   localparam int unsigned FLAG_W = $bits(comparator_flags_t);

   typedef enum logic [2:0] {
      st_idle, st_trickle, st_const_current, st_const_voltage,
      st_done, st_bad_cell
   } charge_state_t;

   typedef enum logic [1:0] {
      cmd_off, cmd_trickle, cmd_full
   } charge_cmd_t;

   typedef struct packed {
      charge_state_t state;
      charge_cmd_t   cmd;
      logic          path_enable;   // input current limit path on
      logic          prev_path;     // path_enable one cycle ago
      logic          status_low;    // charge_status_n pulled low
      logic          recharge_seen; // qualified dip already acted on
   } seq_state_t;

endpackage : charge_seq_pkg

// *** hw/flag_sync.sv ***
// two-stage synchroniser for a vector of comparator flags
`timescale 1ns/1ps
module flag_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // flags
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] first;
      logic [W-1:0] second;
   } sync_state_t;

   sync_state_t s;
   sync_state_t next_s;

   // first stage feeds only the second stage
   always_comb begin
      next_s.first  = d;
      next_s.second = s.first;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.second;

endmodule : flag_sync

// *** hw/interval_timer.sv ***
// saturating interval counter advanced by a divided clock tick
`timescale 1ns/1ps
module interval_timer #(
   parameter int unsigned                                W     = 36,
   parameter logic [W-1:0]                               LIMIT = '1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // control
   input  wire logic         tick,
   input  wire logic         run,
   input  wire logic         clear,
   // status
   output logic      [W-1:0] count,
   output logic              expired
);

   logic [W-1:0] next_count;

   // clear beats run; the count stops at the limit so expiry stays set
   always_comb begin
      next_count = count;
      if (clear) begin
         next_count = '0;
      end else if (run && tick && count < LIMIT) begin
         next_count = count + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count <= '0;
      end else begin
         count <= next_count;
      end
   end

   assign expired = (count >= LIMIT);

endmodule : interval_timer

// *** hw/charge_sequencer.sv ***
// charge cycle sequencer: path lockout, charge modes, timers, status pin
`timescale 1ns/1ps
module charge_sequencer #(
   parameter int unsigned     TICK_CYCLES    = charge_seq_pkg::TICK_CYCLES,
   parameter longint unsigned BAD_CELL_TICKS = charge_seq_pkg::BAD_CELL_TICKS,
   parameter longint unsigned SAFETY_TICKS   = charge_seq_pkg::SAFETY_TICKS,
   parameter longint unsigned RECHARGE_TICKS = charge_seq_pkg::RECHARGE_TICKS
) (
   // clock and reset
   input  wire logic                              clk,
   input  wire logic                              reset,
   // comparator flags, raw from the analog side
   input  wire charge_seq_pkg::comparator_flags_t flags,
   // charger and path control
   output logic                                   input_path_enable,
   output logic                                   bus_undervoltage_lockout,
   output charge_seq_pkg::charge_cmd_t            charge_cmd,
   output charge_seq_pkg::charge_state_t          charge_state,
   // open-drain charge_status_n pin
   output logic                                   charge_status_n_out,
   output logic                                   charge_status_n_oe
);

   localparam int unsigned TW = charge_seq_pkg::TIMER_W;

   charge_seq_pkg::comparator_flags_t f;
   charge_seq_pkg::seq_state_t        s;
   charge_seq_pkg::seq_state_t        next_s;
   logic [15:0]                       div_count;
   logic                              tick;
   logic                              path_rise;
   logic                              recharge_qual;
   logic                              recharge_pulse;
   logic                              start_cycle;
   logic                              bad_cell_expired;
   logic                              safety_expired;
   logic [TW-1:0]                     safety_count;

   ////////////////////////////////////////////////////////////////////////
   // flag synchroniser and timer base

   // flags cross from the analog side, so each is synchronised first
   flag_sync #(.W(charge_seq_pkg::FLAG_W)) u_sync (
      .clk   (clk),
      .reset (reset),
      .d     (flags),
      .q     (f)
   );

   // 1 us tick from the system clock keeps timer widths modest
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_count <= '0;
      end else if (tick) begin
         div_count <= '0;
      end else begin
         div_count <= div_count + 16'h0001;
      end
   end
   assign tick = (div_count == 16'(TICK_CYCLES - 1));

   ////////////////////////////////////////////////////////////////////////
   // interval timers

   // bad cell timer runs only in trickle and holds during a fault
   interval_timer #(.W(TW), .LIMIT(TW'(BAD_CELL_TICKS))) u_bad_cell (
      .clk     (clk),
      .reset   (reset),
      .tick    (tick),
      .run     (s.state == charge_seq_pkg::st_trickle && !f.temp_fault),
      .clear   (s.state != charge_seq_pkg::st_trickle),
      .count   (),
      .expired (bad_cell_expired)
   );

   // safety timer runs in constant voltage, paused by a fault
   interval_timer #(.W(TW), .LIMIT(TW'(SAFETY_TICKS))) u_safety (
      .clk     (clk),
      .reset   (reset),
      .tick    (tick),
      .run     (s.state == charge_seq_pkg::st_const_voltage
                && !f.temp_fault),
      .clear   (start_cycle || recharge_pulse),
      .count   (safety_count),
      .expired (safety_expired)
   );

   // a dip below the recharge level must outlast the filter
   interval_timer #(.W(TW), .LIMIT(TW'(RECHARGE_TICKS))) u_recharge (
      .clk     (clk),
      .reset   (reset),
      .tick    (tick),
      .run     (f.below_recharge),
      .clear   (!f.below_recharge),
      .count   (),
      .expired (recharge_qual)
   );

   // one action per qualified dip, not one per cycle spent below it
   assign recharge_pulse = recharge_qual && !s.recharge_seen;
   assign path_rise      = s.path_enable && !s.prev_path;
   assign start_cycle    = path_rise
      || (s.state == charge_seq_pkg::st_done && recharge_pulse);

   ////////////////////////////////////////////////////////////////////////
   // sequencer next state

   always_comb begin
      next_s = s;
      next_s.prev_path = s.path_enable;
      // input path hysteresis; falling is checked only while on, rising only while off
      if (s.path_enable && (f.bus_below_fall || f.bus_below_out)) begin
         next_s.path_enable = 1'b0;
      end else if (!s.path_enable && f.bus_above_rise
                   && f.bus_above_out) begin
         next_s.path_enable = 1'b1;
      end
      if (recharge_pulse) begin
         next_s.recharge_seen = 1'b1;
      end else if (!f.below_recharge) begin
         next_s.recharge_seen = 1'b0;
      end
      // charge state
      if (!s.path_enable) begin
         next_s.state      = charge_seq_pkg::st_idle;
      end else if (start_cycle) begin
         next_s.status_low = 1'b1;
         next_s.state      = f.below_trickle
            ? charge_seq_pkg::st_trickle
            : charge_seq_pkg::st_const_current;
      end else begin
         unique case (s.state)
            charge_seq_pkg::st_idle: begin
               next_s.state = charge_seq_pkg::st_idle;
            end
            charge_seq_pkg::st_trickle: begin
               if (bad_cell_expired) begin
                  next_s.state      = charge_seq_pkg::st_bad_cell;
                  next_s.status_low = 1'b0;
               end else if (!f.below_trickle) begin
                  next_s.state = charge_seq_pkg::st_const_current;
               end
            end
            charge_seq_pkg::st_const_current: begin
               if (f.cv_mode) begin
                  next_s.state = charge_seq_pkg::st_const_voltage;
               end
            end
            charge_seq_pkg::st_const_voltage: begin
               if (safety_expired) begin
                  next_s.state      = charge_seq_pkg::st_done;
                  next_s.status_low = 1'b0;
               end else if (f.below_c10 && !f.current_limit
                            && !f.temp_fault) begin
                  next_s.status_low = 1'b0;
               end
            end
            charge_seq_pkg::st_done: begin
               next_s.state = charge_seq_pkg::st_done;
            end
            charge_seq_pkg::st_bad_cell: begin
               next_s.state = charge_seq_pkg::st_bad_cell;
            end
         endcase
      end
      // current command follows the state; faults and budget gate it
      next_s.cmd = charge_seq_pkg::cmd_off;
      if (next_s.path_enable && !f.temp_fault
          && !f.over_budget) begin
         unique case (next_s.state)
            charge_seq_pkg::st_trickle: begin
               next_s.cmd = charge_seq_pkg::cmd_trickle;
            end
            charge_seq_pkg::st_const_current,
            charge_seq_pkg::st_const_voltage: begin
               next_s.cmd = charge_seq_pkg::cmd_full;
            end
            charge_seq_pkg::st_idle,
            charge_seq_pkg::st_done,
            charge_seq_pkg::st_bad_cell: begin
               next_s.cmd = charge_seq_pkg::cmd_off;
            end
         endcase
      end
   end

   // state register; reset parks idle with the status pin released
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s <= '{state: charge_seq_pkg::st_idle,
                cmd: charge_seq_pkg::cmd_off,
                default: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   // open drain: the pin is only ever pulled low, never driven high
   assign charge_status_n_out      = 1'b0;
   assign charge_status_n_oe       = s.status_low;
   assign input_path_enable        = s.path_enable;
   assign bus_undervoltage_lockout = !s.path_enable;
   assign charge_cmd               = s.cmd;
   assign charge_state             = s.state;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence in_cv_expired;
      s.state == charge_seq_pkg::st_const_voltage && safety_expired
      && s.path_enable && !start_cycle;
   endsequence

   sequence ended_quiet;
      s.state == charge_seq_pkg::st_done
      && s.cmd == charge_seq_pkg::cmd_off && !charge_status_n_oe;
   endsequence

   chk_path_rise: assert property (
      !s.path_enable && f.bus_above_rise && f.bus_above_out
      |=> input_path_enable)
      else $error("input path not enabled above rising threshold");

   chk_path_fall: assert property (
      s.path_enable && (f.bus_below_fall || f.bus_below_out)
      |=> !input_path_enable ##1 charge_state == charge_seq_pkg::st_idle)
      else $error("input path not dropped below falling threshold");

   chk_trickle_cmd: assert property (
      charge_cmd == charge_seq_pkg::cmd_trickle
      |-> charge_state == charge_seq_pkg::st_trickle)
      else $error("trickle current outside trickle state");

   chk_bad_cell: assert property (
      s.state == charge_seq_pkg::st_trickle && bad_cell_expired
      && s.path_enable && !start_cycle
      |=> charge_state == charge_seq_pkg::st_bad_cell && !charge_status_n_oe)
      else $error("bad cell not declared after trickle limit");

   chk_cc_entry: assert property (
      s.state == charge_seq_pkg::st_trickle && !f.below_trickle
      && !bad_cell_expired && s.path_enable && !start_cycle
      |=> charge_state == charge_seq_pkg::st_const_current)
      else $error("no move to constant current above trickle level");

   chk_budget_gate: assert property (
      f.over_budget |=> charge_cmd == charge_seq_pkg::cmd_off)
      else $error("charge commanded with no input budget left");

   chk_cv_entry: assert property (
      s.state == charge_seq_pkg::st_const_current && f.cv_mode
      && s.path_enable && !start_cycle
      |=> charge_state == charge_seq_pkg::st_const_voltage)
      else $error("constant voltage entry missed");

   chk_safety_end: assert property (
      in_cv_expired |=> ended_quiet)
      else $error("safety expiry did not end the cycle");

   chk_recharge_clear: assert property (
      recharge_pulse |=> safety_count == '0)
      else $error("qualified recharge dip did not clear safety timer");

   chk_restart_clear: assert property (
      path_rise |=> safety_count == '0 && charge_status_n_oe
      && charge_state != charge_seq_pkg::st_idle)
      else $error("lockout cycle did not restart charging");

   chk_status_low: assert property (
      charge_state inside {charge_seq_pkg::st_trickle,
                           charge_seq_pkg::st_const_current}
      |-> charge_status_n_oe)
      else $error("status released during a normal charge cycle");

   chk_c10_hold: assert property (
      s.status_low && (f.current_limit || f.temp_fault)
      && s.state == charge_seq_pkg::st_const_voltage && !safety_expired
      |=> charge_status_n_oe)
      else $error("status released under current limit or fault");

   chk_c10_release: assert property (
      s.status_low && f.below_c10 && !f.current_limit && !f.temp_fault
      && s.state == charge_seq_pkg::st_const_voltage && s.path_enable
      && !start_cycle
      |=> !charge_status_n_oe)
      else $error("status not released at taper in constant voltage");

   chk_fault_cmd: assert property (
      f.temp_fault |=> charge_cmd == charge_seq_pkg::cmd_off)
      else $error("charge current commanded during a temperature fault");

   chk_recharge_start: assert property (
      s.state == charge_seq_pkg::st_done && recharge_pulse && s.path_enable
      |=> charge_status_n_oe && charge_state != charge_seq_pkg::st_done)
      else $error("qualified recharge dip did not start a new cycle");

endmodule : charge_sequencer

// *** test/battery_model.sv ***
// cell and supply model that turns analog levels into comparator flags
`timescale 1ns/1ps
module battery_model #(
   parameter int RISE_MV     = 3800,
   parameter int FALL_MV     = 3700,
   parameter int MARGIN_MV   = 50,
   parameter int TRICKLE_MV  = 2850,
   parameter int RECHARGE_MV = 4100,
   parameter int CV_MV       = 4150
) (
   // analog levels in millivolts
   input  wire logic [15:0]                       bus_mv,
   input  wire logic [15:0]                       out_mv,
   input  wire logic [15:0]                       bat_mv,
   // charger conditions set by the bench
   input  wire logic                              taper,
   input  wire logic                              limit,
   input  wire logic                              hot,
   input  wire logic                              heavy,
   // comparator outputs towards the sequencer
   output charge_seq_pkg::comparator_flags_t      flags
);
   ////////////////////////////////////////////////////////////////////////
   // comparators: levels only, no hysteresis here because the sequencer
   // must hold its own hysteresis between the rise and fall thresholds
   always_comb begin
      flags                = '0;
      flags.bus_above_rise = (bus_mv > RISE_MV);
      flags.bus_above_out  = (bus_mv >= out_mv + MARGIN_MV);
      flags.bus_below_fall = (bus_mv < FALL_MV);
      flags.bus_below_out  = (bus_mv + MARGIN_MV <= out_mv);
      flags.below_trickle  = (bat_mv < TRICKLE_MV);
      flags.cv_mode        = (bat_mv >= CV_MV);
      flags.below_c10      = taper;
      flags.below_recharge = (bat_mv < RECHARGE_MV);
      flags.current_limit  = limit;
      flags.temp_fault     = hot;
      flags.over_budget    = heavy;
   end
endmodule : battery_model

// *** test/tb.sv ***
// self-checking bench for the charge cycle sequencer
`timescale 1ns/1ps
module tb;
   logic                              clk;
   logic                              reset;
   charge_seq_pkg::comparator_flags_t flags;
   logic                              path;
   logic                              lockout;
   charge_seq_pkg::charge_cmd_t       cmd;
   charge_seq_pkg::charge_state_t     state;
   logic                              st_out;
   logic                              st_oe;
   logic                              pin;
   logic [15:0]                       bus_mv;
   logic [15:0]                       out_mv;
   logic [15:0]                       bat_mv;
   logic                              taper;
   logic                              limit;
   logic                              hot;
   logic                              heavy;
   int                                n_errors;
   int                                num_checks;
   int                                cyc;

   ////////////////////////////////////////////////////////////////////////
   // short timer parameters keep the run to a few hundred cycles
   charge_sequencer #(
      .TICK_CYCLES    (2),
      .BAD_CELL_TICKS (20),
      .SAFETY_TICKS   (30),
      .RECHARGE_TICKS (4)
   ) dut (
      .clk                      (clk),
      .reset                    (reset),
      .flags                    (flags),
      .input_path_enable        (path),
      .bus_undervoltage_lockout (lockout),
      .charge_cmd               (cmd),
      .charge_state             (state),
      .charge_status_n_out      (st_out),
      .charge_status_n_oe       (st_oe)
   );

   battery_model model (
      .bus_mv (bus_mv),
      .out_mv (out_mv),
      .bat_mv (bat_mv),
      .taper  (taper),
      .limit  (limit),
      .hot    (hot),
      .heavy  (heavy),
      .flags  (flags)
   );

   // open-drain status pin with its pull-up
   assign pin = st_oe ? st_out : 1'b1;

   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
         n_errors++;
      end
   endtask : check

   // inputs always move 1 ns after the rising edge
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step

   // bounded wait for a state; a timeout ends the run
   task automatic wait_state(input charge_seq_pkg::charge_state_t s,
                             input int lim, output int n);
      n = 0;
      while (state !== s && n < lim) begin
         step(1);
         n++;
      end
      if (state !== s) begin
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, state, s);
         n_errors++;
         close_out();
      end
   endtask : wait_state

   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0; reset = 1'b1; taper = 1'b0; limit = 1'b0;
      hot = 1'b0; heavy = 1'b0; n_errors = 0; num_checks = 0;
      bus_mv = 16'h1388; out_mv = 16'h1374; bat_mv = 16'h09c4;
      repeat (6) @(posedge clk);
      #1;
      reset = 1'b0;
      // reset leaves everything idle and released
      check(path, 8'h00);
      check(lockout, 8'h01);
      check(state, charge_seq_pkg::st_idle);
      check(cmd, charge_seq_pkg::cmd_off);
      check(pin, 8'h01);
      // bus high but only 20 mV above the output: path stays off
      step(10);
      check(path, 8'h00);
      out_mv = 16'h0e10;
      step(2);
      check(path, 8'h00);
      wait_state(charge_seq_pkg::st_trickle, 12, cyc);
      check(path, 8'h01);
      check(lockout, 8'h00);
      check(cmd, charge_seq_pkg::cmd_trickle);
      check(pin, 8'h00);
      $display("test lockout and trickle done");
      // cell never leaves trickle: bad cell after 20 ticks of 2 clocks
      wait_state(charge_seq_pkg::st_bad_cell, 100, cyc);
      check(8'(cyc >= 36), 8'h01);
      check(cmd, charge_seq_pkg::cmd_off);
      $display("test bad cell done");
      // bus falls under the lower threshold, then returns
      bus_mv = 16'h0e42;
      step(8);
      check(path, 8'h00);
      check(state, charge_seq_pkg::st_idle);
      bus_mv = 16'h1388;
      wait_state(charge_seq_pkg::st_trickle, 12, cyc);
      check(pin, 8'h00);
      // system output climbs to the bus margin: path drops, then returns
      out_mv = 16'h13ba;
      step(8);
      check(path, 8'h00);
      check(lockout, 8'h01);
      check(state, charge_seq_pkg::st_idle);
      out_mv = 16'h0e10;
      wait_state(charge_seq_pkg::st_trickle, 12, cyc);
      check(lockout, 8'h00);
      bat_mv = 16'h0dac;
      wait_state(charge_seq_pkg::st_const_current, 12, cyc);
      check(cmd, charge_seq_pkg::cmd_full);
      // load takes the whole input budget
      heavy = 1'b1;
      step(6);
      check(cmd, charge_seq_pkg::cmd_off);
      heavy = 1'b0;
      step(6);
      check(cmd, charge_seq_pkg::cmd_full);
      $display("test restart and budget done");
      // constant voltage, a long temperature pause, then taper
      bat_mv = 16'h1054;
      wait_state(charge_seq_pkg::st_const_voltage, 12, cyc);
      step(20);
      hot = 1'b1;
      step(80);
      check(state, charge_seq_pkg::st_const_voltage);
      check(cmd, charge_seq_pkg::cmd_off);
      check(pin, 8'h00);
      hot = 1'b0;
      limit = 1'b1;
      taper = 1'b1;
      step(10);
      check(pin, 8'h00);
      limit = 1'b0;
      step(6);
      check(pin, 8'h01);
      check(state, charge_seq_pkg::st_const_voltage);
      wait_state(charge_seq_pkg::st_done, 80, cyc);
      check(cmd, charge_seq_pkg::cmd_off);
      taper = 1'b0;
      $display("test safety timer done");
      // a dip shorter than the filter is ignored, a long one recharges
      bat_mv = 16'h0fd2;
      step(3);
      bat_mv = 16'h1054;
      step(10);
      check(state, charge_seq_pkg::st_done);
      bat_mv = 16'h0fd2;
      wait_state(charge_seq_pkg::st_const_current, 40, cyc);
      check(pin, 8'h00);
      check(cmd, charge_seq_pkg::cmd_full);
      bat_mv = 16'h1054;
      wait_state(charge_seq_pkg::st_const_voltage, 12, cyc);
      wait_state(charge_seq_pkg::st_done, 90, cyc);
      check(8'(cyc >= 56), 8'h01);
      $display("test recharge done");
      close_out();
   end
endmodule : tb
